/* File: bfwr_defs.svh */
// Offsets, field positions and reset values of the forwarding window registers
`ifndef BFWR_DEFS_SVH
`define BFWR_DEFS_SVH

`define BFWR_OFF_IO_BOTTOM 8'h1c
`define BFWR_OFF_IO_TOP 8'h1d
`define BFWR_OFF_SEC_STATUS 8'h1e
`define BFWR_OFF_MEM_BOTTOM 8'h20
`define BFWR_OFF_MEM_TOP 8'h22
`define BFWR_OFF_PREF_BOTTOM 8'h24
`define BFWR_OFF_PREF_TOP 8'h26
`define BFWR_OFF_PREF_BOTTOM_UP 8'h28
`define BFWR_OFF_PREF_TOP_UP 8'h2c
`define BFWR_OFF_IO_BOTTOM_UP 8'h30
`define BFWR_OFF_IO_TOP_UP 8'h32

`define BFWR_IO_FIELD_LSB 4
`define BFWR_MEM_FIELD_LSB 4
`define BFWR_IO_WIDTH_IND 4'h1
`define BFWR_WIDE_ADDR_IND 4'h1
`define BFWR_SEC_STATUS_VAL 16'h0000
`define BFWR_IO_LOW_ONES 12'hfff
`define BFWR_MEM_LOW_ONES 20'hfffff

`define BFWR_RST_IO_FIELD 4'h0
`define BFWR_RST_IO_UP 16'h0000
`define BFWR_RST_MEM_FIELD 12'h000
`define BFWR_RST_PREF_UP 32'h0000_0000

`endif

/* File: bfwr_pkg.sv */
// Types shared by the forwarding window register bank
package bfwr_pkg;

  typedef enum logic {
    SPACE_IO = 1'b0,
    SPACE_MEM = 1'b1
  } bfwr_space_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] byteEn;
    logic [31:0] data;
  } bfwr_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } bfwr_cfg_rsp_t;

  typedef struct packed {
    logic valid;
    bfwr_space_t space;
    logic [63:0] addr;
  } bfwr_txn_t;

  typedef struct packed {
    logic valid;
    logic ioHit;
    logic memHit;
    logic prefHit;
    logic forward;
  } bfwr_fwd_t;

endpackage : bfwr_pkg

/* File: bfwr_window_regs.sv */
// Type-1 bridge forwarding window registers with window match logic
`include "bfwr_defs.svh"

module bfwr_window_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire bfwr_pkg::bfwr_cfg_req_t cfgReq,
  output bfwr_pkg::bfwr_cfg_rsp_t cfgRsp,
  input wire bfwr_pkg::bfwr_txn_t txnReq,
  output bfwr_pkg::bfwr_fwd_t fwdRes
);

  localparam logic [5:0] DwIo = 6'(`BFWR_OFF_IO_BOTTOM >> 2);
  localparam logic [5:0] DwMem = 6'(`BFWR_OFF_MEM_BOTTOM >> 2);
  localparam logic [5:0] DwPref = 6'(`BFWR_OFF_PREF_BOTTOM >> 2);
  localparam logic [5:0] DwPrefBotUp = 6'(`BFWR_OFF_PREF_BOTTOM_UP >> 2);
  localparam logic [5:0] DwPrefTopUp = 6'(`BFWR_OFF_PREF_TOP_UP >> 2);
  localparam logic [5:0] DwIoUp = 6'(`BFWR_OFF_IO_BOTTOM_UP >> 2);

  logic [3:0] ioBottom_q, ioBottom_d;
  logic [3:0] ioTop_q, ioTop_d;
  logic [15:0] ioBottomUp_q, ioBottomUp_d;
  logic [15:0] ioTopUp_q, ioTopUp_d;
  logic [11:0] memBottom_q, memBottom_d;
  logic [11:0] memTop_q, memTop_d;
  logic [11:0] prefBottom_q, prefBottom_d;
  logic [11:0] prefTop_q, prefTop_d;
  logic [31:0] prefBottomUp_q, prefBottomUp_d;
  logic [31:0] prefTopUp_q, prefTopUp_d;
  logic [5:0] dw;
  logic [31:0] wrMask;

  assign dw = cfgReq.addr[7:2];

  // Byte enables widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wrMask[gi*8 +: 8] = {8{cfgReq.byteEn[gi]}};
    end
  endgenerate

  // Register writes: only writable fields take data, fixed fields have no storage
  always_comb begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    ioBottom_d = ioBottom_q;
    ioTop_d = ioTop_q;
    ioBottomUp_d = ioBottomUp_q;
    ioTopUp_d = ioTopUp_q;
    memBottom_d = memBottom_q;
    memTop_d = memTop_q;
    prefBottom_d = prefBottom_q;
    prefTop_d = prefTop_q;
    prefBottomUp_d = prefBottomUp_q;
    prefTopUp_d = prefTopUp_q;
    if (cfgReq.wr) begin
      unique case (dw)
        DwIo: begin
          merged = {16'h0000, ioTop_q, 4'h0, ioBottom_q, 4'h0};
          merged = (merged & ~wrMask) | (cfgReq.data & wrMask);
          ioBottom_d = merged[7:4];
          ioTop_d = merged[15:12];
        end
        DwMem: begin
          merged = {memTop_q, 4'h0, memBottom_q, 4'h0};
          merged = (merged & ~wrMask) | (cfgReq.data & wrMask);
          memBottom_d = merged[15:4];
          memTop_d = merged[31:20];
        end
        DwPref: begin
          merged = {prefTop_q, 4'h0, prefBottom_q, 4'h0};
          merged = (merged & ~wrMask) | (cfgReq.data & wrMask);
          prefBottom_d = merged[15:4];
          prefTop_d = merged[31:20];
        end
        DwPrefBotUp: begin
          prefBottomUp_d = (prefBottomUp_q & ~wrMask) | (cfgReq.data & wrMask);
        end
        DwPrefTopUp: begin
          prefTopUp_d = (prefTopUp_q & ~wrMask) | (cfgReq.data & wrMask);
        end
        DwIoUp: begin
          merged = {ioTopUp_q, ioBottomUp_q};
          merged = (merged & ~wrMask) | (cfgReq.data & wrMask);
          ioBottomUp_d = merged[15:0];
          ioTopUp_d = merged[31:16];
        end
        default: begin
          merged = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ioBottom_q <= `BFWR_RST_IO_FIELD;
      ioTop_q <= `BFWR_RST_IO_FIELD;
      ioBottomUp_q <= `BFWR_RST_IO_UP;
      ioTopUp_q <= `BFWR_RST_IO_UP;
      memBottom_q <= `BFWR_RST_MEM_FIELD;
      memTop_q <= `BFWR_RST_MEM_FIELD;
      prefBottom_q <= `BFWR_RST_MEM_FIELD;
      prefTop_q <= `BFWR_RST_MEM_FIELD;
      prefBottomUp_q <= `BFWR_RST_PREF_UP;
      prefTopUp_q <= `BFWR_RST_PREF_UP;
    end else begin
      ioBottom_q <= ioBottom_d;
      ioTop_q <= ioTop_d;
      ioBottomUp_q <= ioBottomUp_d;
      ioTopUp_q <= ioTopUp_d;
      memBottom_q <= memBottom_d;
      memTop_q <= memTop_d;
      prefBottom_q <= prefBottom_d;
      prefTop_q <= prefTop_d;
      prefBottomUp_q <= prefBottomUp_d;
      prefTopUp_q <= prefTopUp_d;
    end
  end

  // Read answer one cycle after the request; unmapped dwords read zero
  bfwr_pkg::bfwr_cfg_rsp_t rsp_q, rsp_d;
  logic [5:0] rdDw_q, rdDw_d;

  always_comb begin
    rsp_d.valid = cfgReq.rd;
    rsp_d.data = 32'h0000_0000;
    rdDw_d = cfgReq.rd ? dw : rdDw_q;
    if (cfgReq.rd) begin
      unique case (dw)
        DwIo: begin
          rsp_d.data = {`BFWR_SEC_STATUS_VAL,
                        ioTop_q, `BFWR_IO_WIDTH_IND,
                        ioBottom_q, `BFWR_IO_WIDTH_IND};
        end
        DwMem: begin
          rsp_d.data = {memTop_q, 4'h0, memBottom_q, 4'h0};
        end
        DwPref: begin
          rsp_d.data = {prefTop_q, `BFWR_WIDE_ADDR_IND,
                        prefBottom_q, `BFWR_WIDE_ADDR_IND};
        end
        DwPrefBotUp: begin
          rsp_d.data = prefBottomUp_q;
        end
        DwPrefTopUp: begin
          rsp_d.data = prefTopUp_q;
        end
        DwIoUp: begin
          rsp_d.data = {ioTopUp_q, ioBottomUp_q};
        end
        default: begin
          rsp_d.data = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '0;
      rdDw_q <= 6'h00;
    end else begin
      rsp_q <= rsp_d;
      rdDw_q <= rdDw_d;
    end
  end

  assign cfgRsp = rsp_q;

  // Window bounds and inclusive match
  logic [31:0] ioLow, ioHigh, memLow, memHigh;
  logic [63:0] prefLow, prefHigh;
  bfwr_pkg::bfwr_fwd_t fwd_q, fwd_d;

  assign ioLow = {ioBottomUp_q, ioBottom_q, 12'h000};
  assign ioHigh = {ioTopUp_q, ioTop_q, `BFWR_IO_LOW_ONES};
  assign memLow = {memBottom_q, 20'h00000};
  assign memHigh = {memTop_q, `BFWR_MEM_LOW_ONES};
  assign prefLow = {prefBottomUp_q, prefBottom_q, 20'h00000};
  assign prefHigh = {prefTopUp_q, prefTop_q, `BFWR_MEM_LOW_ONES};

  always_comb begin
    logic hi0;
    hi0 = (txnReq.addr[63:32] == 32'h0000_0000);
    fwd_d.valid = txnReq.valid;
    fwd_d.ioHit = txnReq.valid && txnReq.space == bfwr_pkg::SPACE_IO && hi0
                  && ioLow <= txnReq.addr[31:0] && txnReq.addr[31:0] <= ioHigh;
    fwd_d.memHit = txnReq.valid && txnReq.space == bfwr_pkg::SPACE_MEM && hi0
                   && memLow <= txnReq.addr[31:0] && txnReq.addr[31:0] <= memHigh;
    fwd_d.prefHit = txnReq.valid && txnReq.space == bfwr_pkg::SPACE_MEM
                    && prefLow <= txnReq.addr && txnReq.addr <= prefHigh;
    fwd_d.forward = fwd_d.ioHit || fwd_d.memHit || fwd_d.prefHit;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_q <= '0;
    end else begin
      fwd_q <= fwd_d;
    end
  end

  assign fwdRes = fwd_q;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_io_width_read: assert property (cfgReq.rd && dw == DwIo |=> cfgRsp.valid
    && cfgRsp.data[3:0] == 4'h1 && cfgRsp.data[11:8] == 4'h1)
    else $error("I/O width nibble not 1h");
  a_status_err_zero: assert property (cfgRsp.valid && rdDw_q == DwIo |->
    cfgRsp.data[31:27] == 5'h00 && cfgRsp.data[24] == 1'b0)
    else $error("Secondary error bits not zero");
  a_status_sel_timing: assert property (cfgRsp.valid && rdDw_q == DwIo |->
    cfgRsp.data[26:25] == 2'h0)
    else $error("Select timing field not 00");
  a_status_cap_zero: assert property (cfgRsp.valid && rdDw_q == DwIo |->
    cfgRsp.data[23] == 1'b0 && cfgRsp.data[21] == 1'b0)
    else $error("Capability bits not zero");
  a_status_rsvd_zero: assert property (cfgRsp.valid && rdDw_q == DwIo |->
    cfgRsp.data[22] == 1'b0 && cfgRsp.data[20:16] == 5'h00)
    else $error("Reserved status bits not zero");
  a_mem_rsvd_zero: assert property (cfgRsp.valid && rdDw_q == DwMem |->
    cfgRsp.data[3:0] == 4'h0 && cfgRsp.data[19:16] == 4'h0)
    else $error("Memory reserved nibble not zero");
  a_pref_wide_ind: assert property (cfgRsp.valid && rdDw_q == DwPref |->
    cfgRsp.data[3:0] == 4'h1)
    else $error("Prefetch wide indicator missing");
  a_io_top_write: assert property (cfgReq.wr && dw == DwIo && cfgReq.byteEn[1] |=>
    ioTop_q == $past(cfgReq.data[15:12]))
    else $error("I/O top field not written");
  a_io_top_edge: assert property (txnReq.valid && txnReq.space == bfwr_pkg::SPACE_IO
    && txnReq.addr == {32'h0, ioTopUp_q, ioTop_q, 12'hfff} && ioLow <= ioHigh
    |=> fwdRes.ioHit && fwdRes.forward)
    else $error("I/O limit address not forwarded");
  a_mem_bottom_edge: assert property (txnReq.valid && txnReq.space == bfwr_pkg::SPACE_MEM
    && txnReq.addr == {32'h0, memBottom_q, 20'h0} && memBottom_q <= memTop_q
    |=> fwdRes.memHit)
    else $error("Memory base address not forwarded");
  a_mem_inverted: assert property (txnReq.valid && memBottom_q > memTop_q |=>
    !fwdRes.memHit)
    else $error("Inverted memory window matched");
  a_io_bottom_write: assert property (cfgReq.wr && dw == DwIo && cfgReq.byteEn[0] |=>
    ioBottom_q == $past(cfgReq.data[7:4]))
    else $error("I/O bottom field not written");
  a_mem_bottom_write: assert property (cfgReq.wr && dw == DwMem
    && cfgReq.byteEn[1:0] == 2'h3 |=> memBottom_q == $past(cfgReq.data[15:4]))
    else $error("Memory bottom field not written");
  a_mem_top_write: assert property (cfgReq.wr && dw == DwMem
    && cfgReq.byteEn[3:2] == 2'h3 |=> memTop_q == $past(cfgReq.data[31:20]))
    else $error("Memory top field not written");
  a_pref_bottom_write: assert property (cfgReq.wr && dw == DwPref
    && cfgReq.byteEn[1:0] == 2'h3 |=> prefBottom_q == $past(cfgReq.data[15:4]))
    else $error("Prefetch bottom field not written");
  a_io_bottom_edge: assert property (txnReq.valid
    && txnReq.space == bfwr_pkg::SPACE_IO && ioLow <= ioHigh
    && txnReq.addr == {32'h0, ioBottomUp_q, ioBottom_q, 12'h000} |=> fwdRes.ioHit)
    else $error("I/O base address not forwarded");
  a_io_above_top: assert property (txnReq.valid
    && txnReq.addr == {32'h0, ioTopUp_q, ioTop_q, 12'hfff} + 64'h1 |=> !fwdRes.ioHit)
    else $error("Address above I/O limit forwarded");
  a_mem_top_edge: assert property (txnReq.valid
    && txnReq.space == bfwr_pkg::SPACE_MEM && memBottom_q <= memTop_q
    && txnReq.addr == {32'h0, memTop_q, 20'hfffff} |=> fwdRes.memHit)
    else $error("Memory limit address not forwarded");
  a_pref_bottom_edge: assert property (txnReq.valid
    && txnReq.space == bfwr_pkg::SPACE_MEM && prefLow <= prefHigh
    && txnReq.addr == {prefBottomUp_q, prefBottom_q, 20'h00000} |=> fwdRes.prefHit)
    else $error("Prefetch base address not forwarded");
  a_io_inverted: assert property (txnReq.valid && ioLow > ioHigh |=>
    !fwdRes.ioHit)
    else $error("Inverted I/O window matched");
  a_pref_inverted: assert property (txnReq.valid && prefLow > prefHigh |=>
    !fwdRes.prefHit)
    else $error("Inverted prefetch window matched");
  a_mem_space_only: assert property (txnReq.valid
    && txnReq.space == bfwr_pkg::SPACE_IO |=> !fwdRes.memHit && !fwdRes.prefHit)
    else $error("I/O query matched a memory window");
  a_io_space_only: assert property (txnReq.valid
    && txnReq.space == bfwr_pkg::SPACE_MEM |=> !fwdRes.ioHit)
    else $error("Memory query matched the I/O window");
  a_high_addr_miss: assert property (txnReq.valid
    && txnReq.addr[63:32] != 32'h0000_0000 |=> !fwdRes.ioHit && !fwdRes.memHit)
    else $error("Wide address matched a 32-bit window");

endmodule : bfwr_window_regs

/* File: bfwr_cfg_host.sv */
// Upstream configuration host model issuing dword accesses
module bfwr_cfg_host (
  input wire logic ref_clk,
  input wire bfwr_pkg::bfwr_cfg_rsp_t cfgRsp,
  output bfwr_pkg::bfwr_cfg_req_t cfgReq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cfgReq = '0;
  // Idle lanes show inverted values so stale data never looks valid
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge ref_clk);
    cfgReq <= '{wr: 1'b1, rd: 1'b0, addr: a, byteEn: be, data: d};
    @(posedge ref_clk);
    cfgReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, byteEn: ~be, data: ~d};
  endtask : cfg_write
  task automatic cfg_read(input logic [7:0] a, output logic v, output logic [31:0] d);
    @(posedge ref_clk);
    cfgReq <= '{wr: 1'b0, rd: 1'b1, addr: a, byteEn: 4'h0, data: 32'h0};
    @(posedge ref_clk);
    cfgReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, byteEn: 4'hf, data: 32'hffff_ffff};
    #1;
    v = cfgRsp.valid;
    d = cfgRsp.data;
  endtask : cfg_read
endmodule : bfwr_cfg_host

/* File: bfwr_window_regs_test.sv */
// Self-checking testbench of the forwarding window registers
module bfwr_window_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  bfwr_pkg::bfwr_cfg_req_t cfgReq;
  bfwr_pkg::bfwr_cfg_rsp_t cfgRsp;
  bfwr_pkg::bfwr_txn_t txnReq = '0;
  bfwr_pkg::bfwr_fwd_t fwdRes;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h9647;
  logic [31:0] r;
  logic [3:0] iob, iot;
  logic [15:0] iobu, iotu;
  logic [11:0] mb, mt, pb, pt;
  logic [31:0] pbu, ptu;

  always #5 ref_clk = ~ref_clk;

  bfwr_cfg_host i_host (.ref_clk(ref_clk), .cfgRsp(cfgRsp), .cfgReq(cfgReq));
  bfwr_window_regs i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .cfgReq(cfgReq),
    .cfgRsp(cfgRsp), .txnReq(txnReq), .fwdRes(fwdRes));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [2:0] exp_hits(input logic sp, input logic [63:0] a);
    logic lo;
    lo = a[63:32] == 32'h0;
    exp_hits[2] = !sp && lo && a[31:0] >= {iobu, iob, 12'h000} && a[31:0] <= {iotu, iot, 12'hfff};
    exp_hits[1] = sp && lo && a[31:0] >= {mb, 20'h0} && a[31:0] <= {mt, 20'hfffff};
    exp_hits[0] = sp && a >= {pbu, pb, 20'h0} && a <= {ptu, pt, 20'hfffff};
  endfunction : exp_hits

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic v;
    logic [31:0] d;
    i_host.cfg_read(a, v, d);
    check("read valid", 32'h1, {31'h0, v});
    check("read data", e, d);
  endtask : rd_chk

  task automatic query(input logic sp, input logic [63:0] a);
    logic [2:0] e;
    e = exp_hits(sp, a);
    @(posedge ref_clk);
    txnReq <= '{valid: 1'b1, space: bfwr_pkg::bfwr_space_t'(sp), addr: a};
    @(posedge ref_clk);
    txnReq <= '{valid: 1'b0, space: bfwr_pkg::SPACE_IO, addr: ~a};
    #1;
    check("forward result", {27'h0, 1'b1, e, |e}, {27'h0, fwdRes});
  endtask : query

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #100us;
    err_total++;
    finish_test();
  end

  initial begin
    logic [63:0] pts[8];
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_chk(8'h1c, 32'h0000_0101);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h24, 32'h0001_0001);
    rd_chk(8'h40, 32'h0000_0000);
    i_host.cfg_write(8'h20, 4'h3, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0000_fff0);
    $display("Test reset and access done");
    for (int n = 0; n < 16; n++) begin
      r = rnd();
      iob = r[3:0];
      iot = r[7:4];
      iobu = {15'h0, r[8]};
      iotu = {15'h0, r[9]};
      pbu = {31'h0, r[10]};
      ptu = {31'h0, r[11]};
      r = rnd();
      mb = r[11:0];
      mt = r[23:12];
      r = rnd();
      pb = r[11:0];
      pt = r[23:12];
      i_host.cfg_write(8'h1c, 4'hf, {16'hffff, iot, 4'he, iob, 4'he});
      i_host.cfg_write(8'h20, 4'hf, {mt, 4'hf, mb, 4'hf});
      i_host.cfg_write(8'h24, 4'hf, {pt, 4'he, pb, 4'he});
      i_host.cfg_write(8'h28, 4'hf, pbu);
      i_host.cfg_write(8'h2c, 4'hf, ptu);
      i_host.cfg_write(8'h30, 4'hf, {iotu, iobu});
      rd_chk(8'h1c, {16'h0, iot, 4'h1, iob, 4'h1});
      rd_chk(8'h20, {mt, 4'h0, mb, 4'h0});
      rd_chk(8'h24, {pt, 4'h1, pb, 4'h1});
      rd_chk(8'h28, pbu);
      rd_chk(8'h2c, ptu);
      rd_chk(8'h30, {iotu, iobu});
      pts = '{{32'h0, iobu, iob, 12'h000}, {32'h0, iotu, iot, 12'hfff},
        {32'h0, iotu, iot, 12'hfff} + 64'h1, {32'h0, iobu, iob, 12'h000} - 64'h1,
        {32'h0, mb, 20'h0}, {32'h0, mt, 20'hfffff}, {pbu, pb, 20'h0},
        {ptu, pt, 20'hfffff} + 64'h1};
      for (int k = 0; k < 8; k++) begin
        query(1'b0, pts[k]);
        query(1'b1, pts[k]);
      end
      r = rnd();
      query(r[0], {31'h0, r[1], rnd()});
    end
    $display("Test random windows done");
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    {iob, iot, iobu, iotu} = 40'h0;
    {pbu, ptu} = 64'h0;
    {mb, mt, pb, pt} = 48'h0;
    rd_chk(8'h1c, 32'h0000_0101);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h24, 32'h0001_0001);
    rd_chk(8'h30, 32'h0000_0000);
    query(1'b1, 64'h0000_0000_000f_ffff);
    query(1'b0, 64'h0000_0000_0000_0fff);
    query(1'b0, 64'h0000_0000_0000_1000);
    $display("Test mid-run reset done");
    finish_test();
  end
endmodule : bfwr_window_regs_test
